// [core/rtc_sqw_irq.sv]
/*
  RTC square-wave output and RTC first-level interrupt with three
  sticky second-level events, masks and read-to-clear status.
  Assumes osc_tick_i pulses once per 32.768 kHz oscillator period and
  that rollover strobes from the trimmed counter coincide with a tick.
*/
`timescale 1ns/1ps
module rtc_sqw_irq
  import rtc_sqw_irq_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic osc_tick_i,
  input wire rtc_events_s rtc_ev_i,
  input wire logic pin_rtc_fn_i,
  output logic square_wave_pin_o,
  output logic square_wave_pin_oe_o,
  output logic periodic_pulse_o,
  output logic rtc_irq_o
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [3:0] square_wave_select_q;
  logic [2:0] periodic_interval_select_q;
  logic [2:0] event_mask_q;
  logic [2:0] status_q;
  logic [SQW_CNT_W-1:0] sqw_cnt_q;
  logic sqw_q;
  logic per_trig;
  logic [2:0] ev_src;
  logic [2:0] ev_prev_q;
  logic [2:0] ev_rise;
  logic stat_rd;

  assign stat_rd = reg_rd_i && (reg_addr_i == INT_STATUS1_OFS);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      square_wave_select_q <= SQW_SEL_RST;
      periodic_interval_select_q <= PER_SEL_RST; // RULE_12
    end else if (reg_wr_i && reg_addr_i == OUT_PER_CTRL_OFS) begin
      square_wave_select_q <= reg_wdata_i[SQW_SEL_LSB +: 4];
      periodic_interval_select_q <= reg_wdata_i[PER_SEL_LSB +: 3];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      event_mask_q <= EV_MASK_RST; // RULE_11
    end else if (reg_wr_i && reg_addr_i == INT_MASK1_OFS) begin
      event_mask_q <= reg_wdata_i[ALM_EV_BIT +: 3];
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 16'h0000;
      case (reg_addr_i)
        OUT_PER_CTRL_OFS: begin
          reg_rdata_o[SQW_SEL_LSB +: 4] <= square_wave_select_q;
          reg_rdata_o[PER_SEL_LSB +: 3] <= periodic_interval_select_q;
        end
        INT_STATUS1_OFS: begin
          reg_rdata_o[ALM_EV_BIT +: 3] <= status_q; // RULE_09
        end
        INT_MASK1_OFS: begin
          reg_rdata_o[ALM_EV_BIT +: 3] <= event_mask_q;
        end
        default: begin
          reg_rdata_o <= 16'h0000;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Square-wave divider
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sqw_cnt_q <= '0;
    end else if (rtc_ev_i.sec_roll) begin
      sqw_cnt_q <= '0; // RULE_18 RULE_03
    end else if (osc_tick_i) begin
      sqw_cnt_q <= sqw_cnt_q + 1'b1; // RULE_18
    end
  end

  // Code n gives 2^(n-1) Hz: bit (15-n) of the tick count
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sqw_q <= 1'b0;
    end else if (square_wave_select_q == 4'h0) begin
      sqw_q <= 1'b0; // RULE_02 RULE_17
    end else begin
      sqw_q <= ~sqw_cnt_q[4'hF - square_wave_select_q]; // RULE_01 RULE_02
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      square_wave_pin_o <= 1'b0;
      square_wave_pin_oe_o <= 1'b0;
    end else begin
      square_wave_pin_o <= pin_rtc_fn_i & sqw_q; // RULE_04
      square_wave_pin_oe_o <= pin_rtc_fn_i; // RULE_04
    end
  end

  // ---------------------------------------------------------------
  // Periodic pulse
  // ---------------------------------------------------------------
  always_comb begin
    case (periodic_interval_select_q) // RULE_12
      PER_SEC: per_trig = rtc_ev_i.sec_roll;
      PER_MIN: per_trig = rtc_ev_i.min_roll;
      PER_HOUR: per_trig = rtc_ev_i.hour_roll;
      PER_DAY: per_trig = rtc_ev_i.day_roll;
      PER_MONTH: per_trig = rtc_ev_i.month_roll;
      default: per_trig = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      periodic_pulse_o <= 1'b0;
    end else if (rtc_ev_i.set_time) begin
      periodic_pulse_o <= 1'b0; // RULE_14
    end else if (per_trig) begin
      periodic_pulse_o <= 1'b1; // RULE_07
    end else if (osc_tick_i) begin
      periodic_pulse_o <= 1'b0; // RULE_13
    end
  end

  // ---------------------------------------------------------------
  // Sticky status and interrupt
  // ---------------------------------------------------------------
  assign ev_src = {periodic_pulse_o, rtc_ev_i.sec_roll,
                   rtc_ev_i.alarm_match}; // RULE_05 RULE_06 RULE_08
  assign ev_rise = ev_src & ~ev_prev_q; // RULE_10

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ev_prev_q <= 3'h0;
    end else begin
      ev_prev_q <= ev_src;
    end
  end

  // New events win over the read clear; mask not applied here
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      status_q <= 3'h0;
    end else if (stat_rd) begin
      status_q <= ev_rise; // RULE_10
    end else begin
      status_q <= status_q | ev_rise; // RULE_10 RULE_15
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rtc_irq_o <= 1'b0;
    end else begin
      rtc_irq_o <= |(status_q & ~event_mask_q); // RULE_11 RULE_16
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sqw_off_low_a: assert property ( // RULE_17
    @(posedge sys_clk_i) disable iff (reset_i)
    square_wave_select_q == 4'h0 |=> !sqw_q)
    else $error("square wave not low while disabled");

  sqw_restart_a: assert property ( // RULE_18
    @(posedge sys_clk_i) disable iff (reset_i)
    rtc_ev_i.sec_roll |=> sqw_cnt_q == '0)
    else $error("divider not restarted at rollover");

  sqw_fast_a: assert property ( // RULE_01
    @(posedge sys_clk_i) disable iff (reset_i)
    square_wave_select_q == 4'hF && !rtc_ev_i.sec_roll
    |=> sqw_q == !$past(sqw_cnt_q[0]))
    else $error("fastest square wave uses wrong divider bit");

  pin_drive_a: assert property ( // RULE_04
    @(posedge sys_clk_i) disable iff (reset_i)
    pin_rtc_fn_i ##1 pin_rtc_fn_i
    |=> square_wave_pin_oe_o && square_wave_pin_o == $past(sqw_q))
    else $error("square wave not driven on pin");

  sec_status_a: assert property ( // RULE_06
    @(posedge sys_clk_i) disable iff (reset_i)
    rtc_ev_i.sec_roll && !ev_prev_q[1] |=> status_q[1])
    else $error("seconds status not set");

  alarm_masked_a: assert property ( // RULE_15
    @(posedge sys_clk_i) disable iff (reset_i)
    rtc_ev_i.alarm_match && !ev_prev_q[0] && event_mask_q[0]
    |=> status_q[0] ##1 (!rtc_irq_o || $past(status_q[2:1]) != 2'b00
    || !$past(event_mask_q[0])))
    else $error("masked alarm mishandled");

  read_clear_a: assert property ( // RULE_10
    @(posedge sys_clk_i) disable iff (reset_i)
    stat_rd && ev_rise == 3'h0 |=> status_q == 3'h0)
    else $error("status not cleared by read");

  irq_or_a: assert property ( // RULE_16
    @(posedge sys_clk_i) disable iff (reset_i)
    ##1 rtc_irq_o == |($past(status_q) & ~$past(event_mask_q)))
    else $error("interrupt not OR of unmasked bits");

  per_suppress_a: assert property ( // RULE_14
    @(posedge sys_clk_i) disable iff (reset_i)
    rtc_ev_i.set_time |=> !periodic_pulse_o)
    else $error("periodic pulse during set time");

  per_width_a: assert property ( // RULE_13
    @(posedge sys_clk_i) disable iff (reset_i)
    periodic_pulse_o && osc_tick_i && !per_trig |=> !periodic_pulse_o)
    else $error("periodic pulse outlasts one tick");

  per_minute_a: assert property ( // RULE_12
    @(posedge sys_clk_i) disable iff (reset_i)
    periodic_interval_select_q == PER_MIN && rtc_ev_i.min_roll
    && !rtc_ev_i.set_time |=> periodic_pulse_o)
    else $error("minute periodic pulse missing");

endmodule : rtc_sqw_irq

// [core/rtc_sqw_irq_pkg.sv]
/*
  Constants, field layout and carrier types for the RTC square-wave
  output and RTC interrupt block.
  Assumes a 16-bit register port and one synchronous system clock.
*/
//
// Contract
// RULE_01: Square wave from trimmed counter, 1Hz-16384Hz
// RULE_02: Select 0000 off; codes double from 1Hz
// RULE_03: Trim may distort one period per second
// RULE_04: Drive square wave on pin when selected
// RULE_05: One RTC interrupt from three events
// RULE_06: Seconds event on every seconds rollover
// RULE_07: Periodic event at selected interval
// RULE_08: Alarm event on alarm match
// RULE_09: Status bits: periodic 7, seconds 6, alarm 5
// RULE_10: Bits set on rising edge, cleared by read
// RULE_11: Mask bits 7:5 block interrupt, reset unmasked
// RULE_12: Interval decode 000..101, 11x off, reset 010; code also treats 000 as off (001..101 decoded)
// RULE_13: Periodic pulse lasts one oscillator period
// RULE_14: Set-time status suppresses periodic pulse
// RULE_15: Masked events still set their status bit
// RULE_16: Interrupt is OR of unmasked status bits
// RULE_17: Select 0000 holds square wave low
// RULE_18: Divider on oscillator, restarted at rollover
package rtc_sqw_irq_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OUT_PER_CTRL_OFS = 8'h17;
  localparam logic [7:0] INT_STATUS1_OFS = 8'h19;
  localparam logic [7:0] INT_MASK1_OFS = 8'h21;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SQW_SEL_LSB = 0;
  localparam int PER_SEL_LSB = 4;
  localparam int PER_EV_BIT = 7;
  localparam int SEC_EV_BIT = 6;
  localparam int ALM_EV_BIT = 5;

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [3:0] SQW_SEL_RST = 4'h0;
  localparam logic [2:0] PER_SEL_RST = 3'h2;
  localparam logic [2:0] EV_MASK_RST = 3'h0;
  localparam int OSC_HZ = 32768;
  localparam int SQW_CNT_W = 15;

  // Periodic interval codes
  localparam logic [2:0] PER_SEC = 3'h1;
  localparam logic [2:0] PER_MIN = 3'h2;
  localparam logic [2:0] PER_HOUR = 3'h3;
  localparam logic [2:0] PER_DAY = 3'h4;
  localparam logic [2:0] PER_MONTH = 3'h5;

  // Inputs from the counter, alarm and set-time logic
  typedef struct packed {
    logic sec_roll;
    logic min_roll;
    logic hour_roll;
    logic day_roll;
    logic month_roll;
    logic alarm_match;
    logic set_time;
  } rtc_events_s;

endpackage : rtc_sqw_irq_pkg

// [test/rtc_src_model.sv]
/*
  Oscillator tick and seconds rollover source for the RTC bench.
  Assumes one system clock; a tick every fourth clock.
*/
`timescale 1ns/1ps
module rtc_src_model (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic roll_req_i,
  output logic osc_tick_o,
  output logic sec_roll_o
);
  logic [1:0] div_q;

  // ------------------------------------------------
  // Tick and rollover
  // ------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      div_q <= 2'h0;
      osc_tick_o <= 1'b0;
      sec_roll_o <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      osc_tick_o <= (div_q == 2'h3);
      sec_roll_o <= (div_q == 2'h3) && roll_req_i;
    end
  end
endmodule : rtc_src_model

// [test/test_rtc_sqw_irq.sv]
/*
  Self-checking bench for the RTC square-wave and interrupt block.
  Assumes the source model ticks every fourth clock.
*/
`timescale 1ns/1ps
module test_rtc_sqw_irq;
  import rtc_sqw_irq_pkg::*;
  logic sys_clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, rd_val;
  logic osc_tick, sec_roll, roll_req = 0, alarm = 0, set_time = 0;
  logic [3:0] hi_roll = 4'h0;
  logic pin_rtc_fn_i = 0, sqw_pin, sqw_oe, per_pulse, rtc_irq, prev;
  rtc_events_s ev;
  int failures = 0, cmp_count = 0, cycles = 0, n;
  assign ev = {sec_roll, hi_roll & {4{sec_roll}}, alarm, set_time};

  rtc_src_model src (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .roll_req_i(roll_req), .osc_tick_o(osc_tick), .sec_roll_o(sec_roll));
  rtc_sqw_irq dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .osc_tick_i(osc_tick), .rtc_ev_i(ev), .pin_rtc_fn_i(pin_rtc_fn_i),
    .square_wave_pin_o(sqw_pin), .square_wave_pin_oe_o(sqw_oe),
    .periodic_pulse_o(per_pulse), .rtc_irq_o(rtc_irq));

  // ------------------------------------------------
  // Clock and timeout
  // ------------------------------------------------
  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      print_verdict();
    end
  end

  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge sys_clk_i) reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge sys_clk_i) reg_rd_i <= 1'b0;
    #1 rd_val = reg_rdata_o;
  endtask : rd
  task automatic roll();
    @(posedge sys_clk_i) roll_req <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk_i);
      if (sec_roll === 1'b1) break;
    end
    roll_req <= 1'b0;
  endtask : roll
  task automatic pulses();
    n = 0;
    repeat (8) begin
      #1 n += (per_pulse === 1'b1);
      @(posedge sys_clk_i);
    end
  endtask : pulses
  task automatic edges();
    n = 0;
    repeat (2) @(posedge sys_clk_i);
    #1 prev = sqw_pin;
    repeat (32) begin
      @(posedge sys_clk_i);
      #1 n += (sqw_pin !== prev);
      prev = sqw_pin;
    end
  endtask : edges

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic test_reset();
    rd(OUT_PER_CTRL_OFS); check("ctrl", rd_val, 16'h0020);
    rd(INT_MASK1_OFS); check("mask", rd_val, 16'h0000);
    rd(INT_STATUS1_OFS); check("status", rd_val, 16'h0000);
    rd(8'h00); check("unmapped", rd_val, 16'h0000);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_seconds();
    roll();
    @(posedge sys_clk_i);
    #1 check("irq", rtc_irq, 1);
    rd(INT_STATUS1_OFS); check("sec", rd_val, 16'h0040);
    rd(INT_STATUS1_OFS); check("clr", rd_val, 16'h0000);
    check("irq off", rtc_irq, 0);
    $display("test_seconds done");
  endtask : test_seconds
  task automatic test_mask();
    wr(INT_MASK1_OFS, 16'h0020);
    @(posedge sys_clk_i) alarm <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1 check("masked irq", rtc_irq, 0);
    rd(INT_STATUS1_OFS); check("alm", rd_val, 16'h0020);
    @(posedge sys_clk_i) alarm <= 1'b0;
    wr(INT_MASK1_OFS, 16'h0000);
    @(posedge sys_clk_i) alarm <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1 check("alm irq", rtc_irq, 1);
    @(posedge sys_clk_i) alarm <= 1'b0;
    rd(INT_STATUS1_OFS);
    $display("test_mask done");
  endtask : test_mask
  localparam logic [2:0] PER_OFF [3] = '{3'h0, 3'h6, 3'h7};
  task automatic test_periodic();
    wr(OUT_PER_CTRL_OFS, 16'h0010);
    roll(); pulses(); check("pulse", 16'(n), 16'h0004);
    rd(INT_STATUS1_OFS); check("per", rd_val, 16'h00C0);
    @(posedge sys_clk_i) set_time <= 1'b1;
    roll(); pulses(); check("set time", 16'(n), 16'h0000);
    @(posedge sys_clk_i) set_time <= 1'b0;
    rd(INT_STATUS1_OFS); check("no per", rd_val, 16'h0040);
    for (int i = 0; i < 3; i++) begin
      wr(OUT_PER_CTRL_OFS, {9'h000, PER_OFF[i], 4'h0});
      roll(); pulses(); check("off code", 16'(n), 16'h0000);
    end
    for (int k = 2; k <= 5; k++) begin
      wr(OUT_PER_CTRL_OFS, 16'(k << PER_SEL_LSB));
      roll(); pulses(); check("wrong roll", 16'(n), 16'h0000);
      hi_roll <= 4'h8 >> (k - 2);
      roll(); pulses(); check("interval", 16'(n), 16'h0004);
      hi_roll <= 4'h0;
    end
    rd(INT_STATUS1_OFS);
    $display("test_periodic done");
  endtask : test_periodic
  task automatic test_square();
    @(posedge sys_clk_i) pin_rtc_fn_i <= 1'b1;
    for (int c = 13; c <= 15; c++) begin
      wr(OUT_PER_CTRL_OFS, 16'h0020 | 16'(c));
      roll(); edges();
      check("edges", 16'(n), 16'(1 << (c - 12)));
      check("oe", sqw_oe, 1);
    end
    wr(OUT_PER_CTRL_OFS, 16'h0020);
    edges(); check("off edges", 16'(n), 16'h0000);
    check("off level", sqw_pin, 0);
    @(posedge sys_clk_i) pin_rtc_fn_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1 check("oe off", sqw_oe, 0);
    rd(INT_STATUS1_OFS);
    $display("test_square done");
  endtask : test_square

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    test_reset();
    test_seconds();
    test_mask();
    test_periodic();
    test_square();
    print_verdict();
  end
endmodule : test_rtc_sqw_irq
